/* File: rtl/ssl_loader.sv */
`timescale 1ns/100ps
`default_nettype none
module ssl_loader #(
    parameter int SETTLE_CYCLES = ssl_pkg::SETTLE_CYCLES,
    parameter int MIN_PULSE_CYCLES = ssl_pkg::MIN_PULSE_CYCLES,
    parameter int MAX_PULSE_CYCLES = ssl_pkg::MAX_PULSE_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ssl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ssl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [ssl_pkg::DATA_W-1:0] reg_rdata,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic load_latch_strobe,
    input wire logic transmit_select_n,
    input wire logic receive_select_n,
    input wire logic tx_data_in,
    output logic lock_indicator,
    output logic tx_enable,
    output logic rx_enable,
    output logic tx_mod_data,
    output logic [ssl_pkg::DIV_W-1:0] divide_total,
    output logic [ssl_pkg::REF_W-1:0] ref_divide
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);
    localparam int PULSE_W = $clog2(MAX_PULSE_CYCLES + 2);

    generate
        if (SETTLE_CYCLES < 1 || MIN_PULSE_CYCLES < 1 || MAX_PULSE_CYCLES <= MIN_PULSE_CYCLES) begin : g_bad
            $error("ssl_loader: timing parameters out of range");
        end
    endgenerate

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [5:0] pins_s;
    logic sclk_s;
    logic sdata_s;
    logic strobe_s;
    logic tx_sel_n_s;
    logic rx_sel_n_s;
    logic txd_s;

    ssl_sync #(
        .WIDTH(6),
        .RESET_VAL(6'h18)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({transmit_select_n, receive_select_n, serial_clock, serial_data, load_latch_strobe, tx_data_in}),
        .sync_out(pins_s)
    );

    assign tx_sel_n_s = pins_s[5];
    assign rx_sel_n_s = pins_s[4];
    assign sclk_s = pins_s[3];
    assign sdata_s = pins_s[2];
    assign strobe_s = pins_s[1];
    assign txd_s = pins_s[0];

    // ************************************************************
    // edge detection and shift register
    // ************************************************************
    logic sclk_d_r;
    logic strobe_d_r;
    logic txd_d_r;
    logic [ssl_pkg::SR_WIDTH-1:0] shift_r;
    wire sclk_rise = sclk_s & ~sclk_d_r;
    wire strobe_rise = strobe_s & ~strobe_d_r;
    wire txd_edge = txd_s ^ txd_d_r;

    // delayed copies for edge finding
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_d_r <= 1'b0;
            strobe_d_r <= 1'b0;
            txd_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
            strobe_d_r <= strobe_s;
            txd_d_r <= txd_s;
        end
    end

    // data bit taken on each rising serial clock edge, first bit ends at the top
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_r <= '0;
        end else if (sclk_rise) begin
            shift_r <= {shift_r[ssl_pkg::SR_WIDTH-2:0], sdata_s};
        end
    end

    // ************************************************************
    // word decode and range checks
    // ************************************************************
    ssl_pkg::ssl_ref_word_type ref_cand;
    ssl_pkg::ssl_prog_word_type prog_cand;
    ssl_pkg::ssl_ref_word_type ref_r;
    ssl_pkg::ssl_prog_word_type prog_r;
    logic ref_loaded_r;
    logic prog_loaded_r;

    assign ref_cand = ssl_pkg::ssl_ref_word_type'(shift_r[ssl_pkg::SR_WIDTH-1:1]);
    assign prog_cand = ssl_pkg::ssl_prog_word_type'(shift_r[ssl_pkg::SR_WIDTH-1:1]);

    wire to_ref = shift_r[ssl_pkg::TARGET_BIT] == ssl_pkg::TARGET_REF;
    wire ref_ok = ref_cand.ref_count >= ssl_pkg::REF_MIN;
    wire prog_ok = (prog_cand.prog_count >= ssl_pkg::PROG_MIN)
        && ({4'h0, prog_cand.swallow_count} < prog_cand.prog_count);
    wire load_ref = strobe_rise & to_ref & ref_ok;
    wire load_prog = strobe_rise & ~to_ref & prog_ok;
    wire load_bad = strobe_rise & ~(to_ref ? ref_ok : prog_ok);

    // latches: either word may come first, a bad word leaves its latch alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_r <= ssl_pkg::REF_RESET;
            prog_r <= ssl_pkg::PROG_RESET;
            ref_loaded_r <= 1'b0;
            prog_loaded_r <= 1'b0;
        end else begin
            if (load_ref) begin
                ref_r <= ref_cand;
                ref_loaded_r <= 1'b1;
            end
            if (load_prog) begin
                prog_r <= prog_cand;
                prog_loaded_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // division ratio
    // ************************************************************
    wire [ssl_pkg::DIV_W-1:0] mn_prod = ref_r.prescaler_128
        ? {prog_r.prog_count, 7'h00}
        : {1'b0, prog_r.prog_count, 6'h00};
    wire [ssl_pkg::DIV_W-1:0] div_nxt = mn_prod + {11'h000, prog_r.swallow_count};

    // ratio outputs held in flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divide_total <= '0;
            ref_divide <= '0;
        end else begin
            divide_total <= div_nxt;
            ref_divide <= ref_r.ref_count;
        end
    end

    // ************************************************************
    // lock tracking
    // ************************************************************
    ssl_pkg::ssl_lock_state_type lock_state_r;
    ssl_pkg::ssl_lock_state_type lock_state_nxt;
    logic [SETTLE_W-1:0] settle_cnt_r;
    logic [1:0] ctrl_r;
    wire both_loaded = ref_loaded_r & prog_loaded_r;
    wire new_word = load_ref | load_prog;
    wire settle_done = settle_cnt_r == SETTLE_W'(SETTLE_CYCLES - 1);

    // any accepted word restarts the settle time
    always_comb begin
        lock_state_nxt = lock_state_r;
        unique case (lock_state_r)
            ssl_pkg::LK_IDLE: begin
                if (both_loaded) begin
                    lock_state_nxt = ssl_pkg::LK_SETTLE;
                end
            end
            ssl_pkg::LK_SETTLE: begin
                if (new_word) begin
                    lock_state_nxt = ssl_pkg::LK_SETTLE;
                end else if (settle_done) begin
                    lock_state_nxt = ssl_pkg::LK_LOCKED;
                end
            end
            ssl_pkg::LK_LOCKED: begin
                if (new_word) begin
                    lock_state_nxt = ssl_pkg::LK_SETTLE;
                end
            end
            default: begin
                lock_state_nxt = ssl_pkg::LK_IDLE;
            end
        endcase
    end

    // state and settle counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_state_r <= ssl_pkg::LK_IDLE;
            settle_cnt_r <= '0;
        end else begin
            lock_state_r <= lock_state_nxt;
            if (lock_state_r != ssl_pkg::LK_SETTLE || new_word) begin
                settle_cnt_r <= '0;
            end else if (!settle_done) begin
                settle_cnt_r <= settle_cnt_r + 1'b1;
            end
        end
    end

    wire locked = (lock_state_r == ssl_pkg::LK_LOCKED) & ~ctrl_r[ssl_pkg::CTRL_LOCK_OFF];

    // ************************************************************
    // comparison frequency output, used when lock select bit is set
    // ************************************************************
    logic [ssl_pkg::REF_W-1:0] fdiv_cnt_r;
    logic fout_r;
    wire fdiv_wrap = fdiv_cnt_r >= ref_r.ref_count - 1'b1;

    // toggles once every reference count of clocks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fdiv_cnt_r <= '0;
            fout_r <= 1'b0;
        end else if (!ref_loaded_r || fdiv_wrap) begin
            fdiv_cnt_r <= '0;
            fout_r <= ref_loaded_r & ~fout_r;
        end else begin
            fdiv_cnt_r <= fdiv_cnt_r + 1'b1;
        end
    end

    // lock pin: lock level unless the divided frequency is selected
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_indicator <= 1'b0;
        end else if (ref_r.lock_output_select_bit) begin
            lock_indicator <= fout_r;
        end else begin
            lock_indicator <= locked;
        end
    end

    // ************************************************************
    // transmit and receive select
    // ************************************************************
    wire tx_sel = ~tx_sel_n_s & rx_sel_n_s;
    wire rx_sel = ~rx_sel_n_s & tx_sel_n_s;
    wire sel_conflict = ~tx_sel_n_s & ~rx_sel_n_s;

    // both low selects neither path
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_enable <= 1'b0;
            rx_enable <= 1'b0;
            tx_mod_data <= 1'b0;
        end else begin
            tx_enable <= tx_sel;
            rx_enable <= rx_sel;
            tx_mod_data <= tx_sel & txd_s;
        end
    end

    // ************************************************************
    // transmit data pulse width watch
    // ************************************************************
    logic [PULSE_W-1:0] pulse_cnt_r;
    logic pulse_first_r;
    wire check_on = ctrl_r[ssl_pkg::CTRL_PULSE_CHECK] & tx_sel;
    // count lags the level length by one cycle, so both limits compare one lower
    wire pulse_short = check_on & txd_edge & ~pulse_first_r
        & (pulse_cnt_r < PULSE_W'(MIN_PULSE_CYCLES - 1));
    wire pulse_long = check_on & ~txd_edge & (pulse_cnt_r == PULSE_W'(MAX_PULSE_CYCLES - 1));

    // counts the current level; first level after enable is not judged short
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_cnt_r <= '0;
            pulse_first_r <= 1'b1;
        end else if (!check_on) begin
            pulse_cnt_r <= '0;
            pulse_first_r <= 1'b1;
        end else if (txd_edge) begin
            pulse_cnt_r <= '0;
            pulse_first_r <= 1'b0;
        end else if (pulse_cnt_r <= PULSE_W'(MAX_PULSE_CYCLES)) begin
            pulse_cnt_r <= pulse_cnt_r + 1'b1;
        end
    end

    // ************************************************************
    // register port
    // ************************************************************
    logic range_err_r;
    logic short_err_r;
    logic long_err_r;
    wire wr_status = reg_write & (reg_addr == ssl_pkg::ADDR_STATUS);
    wire wr_ctrl = reg_write & (reg_addr == ssl_pkg::ADDR_CTRL);

    // sticky fault flags, write one to clear, a new event wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            range_err_r <= 1'b0;
            short_err_r <= 1'b0;
            long_err_r <= 1'b0;
        end else begin
            range_err_r <= load_bad | (range_err_r & ~(wr_status & reg_wdata[ssl_pkg::ST_RANGE_ERR]));
            short_err_r <= pulse_short | (short_err_r & ~(wr_status & reg_wdata[ssl_pkg::ST_PULSE_SHORT]));
            long_err_r <= pulse_long | (long_err_r & ~(wr_status & reg_wdata[ssl_pkg::ST_PULSE_LONG]));
        end
    end

    // control bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= ssl_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= reg_wdata[1:0];
        end
    end

    logic [ssl_pkg::DATA_W-1:0] status_word;
    logic [ssl_pkg::DATA_W-1:0] rd_sel;

    // status word assembly
    always_comb begin
        status_word = '0;
        status_word[ssl_pkg::ST_LOCKED] = locked;
        status_word[ssl_pkg::ST_REF_LOADED] = ref_loaded_r;
        status_word[ssl_pkg::ST_PROG_LOADED] = prog_loaded_r;
        status_word[ssl_pkg::ST_RANGE_ERR] = range_err_r;
        status_word[ssl_pkg::ST_PULSE_SHORT] = short_err_r;
        status_word[ssl_pkg::ST_PULSE_LONG] = long_err_r;
        status_word[ssl_pkg::ST_SEL_CONFLICT] = sel_conflict;
        status_word[ssl_pkg::ST_TX_EN] = tx_enable;
        status_word[ssl_pkg::ST_RX_EN] = rx_enable;
    end

    // read select, unmapped offsets read zero
    always_comb begin
        unique case (reg_addr)
            ssl_pkg::ADDR_STATUS: rd_sel = status_word;
            ssl_pkg::ADDR_REF: rd_sel = {14'h0000, ref_r};
            ssl_pkg::ADDR_PROG: rd_sel = {14'h0000, prog_r};
            ssl_pkg::ADDR_CTRL: rd_sel = {30'h00000000, ctrl_r};
            default: rd_sel = '0;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            reg_rdata <= rd_sel;
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule
`default_nettype wire

/* File: pkg/ssl_pkg.sv */
package ssl_pkg;

    // ************************************************************
    // serial word layout
    // ************************************************************
    localparam int SR_WIDTH = 19;
    localparam int PROG_W = 11;
    localparam int SWAL_W = 7;
    localparam int REF_W = 14;
    localparam int TARGET_BIT = 0;
    localparam logic TARGET_REF = 1'b1;
    localparam logic [PROG_W-1:0] PROG_MIN = 11'h003;
    localparam logic [REF_W-1:0] REF_MIN = 14'h0003;
    localparam int DIV_W = 18;

    // reference word: op bits at the head, then prescaler select, count, target
    typedef struct packed {
        logic charge_pump_sel;
        logic lock_output_select_bit;
        logic phase_polarity_bit;
        logic prescaler_128;
        logic [REF_W-1:0] ref_count;
    } ssl_ref_word_type;

    // program word: program count then swallow count, target last
    typedef struct packed {
        logic [PROG_W-1:0] prog_count;
        logic [SWAL_W-1:0] swallow_count;
    } ssl_prog_word_type;

    localparam ssl_ref_word_type REF_RESET = 18'h00000;
    localparam ssl_prog_word_type PROG_RESET = 18'h00000;

    // ************************************************************
    // register port
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_REF = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_PROG = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'hC;

    localparam int ST_LOCKED = 0;
    localparam int ST_REF_LOADED = 1;
    localparam int ST_PROG_LOADED = 2;
    localparam int ST_RANGE_ERR = 3;
    localparam int ST_PULSE_SHORT = 4;
    localparam int ST_PULSE_LONG = 5;
    localparam int ST_SEL_CONFLICT = 6;
    localparam int ST_TX_EN = 7;
    localparam int ST_RX_EN = 8;

    localparam int CTRL_PULSE_CHECK = 0;
    localparam int CTRL_LOCK_OFF = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int SETTLE_TIME_US = 30000;
    localparam int MIN_PULSE_US = 100;
    localparam int MAX_PULSE_MS = 15;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_PULSE_CYCLES = (MIN_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MAX_PULSE_CYCLES = (MAX_PULSE_MS * 1000000) / CLK_PERIOD_NS;

    // lock tracker states
    typedef enum logic [2:0] {
        LK_IDLE = 3'b001,
        LK_SETTLE = 3'b010,
        LK_LOCKED = 3'b100
    } ssl_lock_state_type;

endpackage

/* File: rtl/ssl_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// two flop synchroniser for pins from outside the clock domain
// ************************************************************
module ssl_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule
`default_nettype wire

/* File: tb/ssl_loader_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// port checker for the loader
// ****
module ssl_loader_properties #(
    parameter int SETTLE_CYCLES = 20,
    parameter int MIN_PULSE_CYCLES = 4,
    parameter int MAX_PULSE_CYCLES = 40
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_read,
    input wire logic [ssl_pkg::DATA_W-1:0] reg_rdata,
    input wire logic load_latch_strobe,
    input wire logic transmit_select_n,
    input wire logic receive_select_n,
    input wire logic lock_indicator,
    input wire logic tx_enable,
    input wire logic rx_enable,
    input wire logic [ssl_pkg::DIV_W-1:0] divide_total,
    input wire logic [ssl_pkg::REF_W-1:0] ref_divide
);
    logic [3:0] pin_age_r;
    logic [3:0] strobe_age_r;
    int settle_r;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ages since select pin change, strobe rise and ratio change
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_age_r <= 4'h0;
            strobe_age_r <= 4'hF;
            settle_r <= 0;
        end else begin
            pin_age_r <= ($changed(transmit_select_n) || $changed(receive_select_n)) ? 4'h0
                : pin_age_r + {3'h0, pin_age_r != 4'hF};
            strobe_age_r <= $rose(load_latch_strobe) ? 4'h0 : strobe_age_r + {3'h0, strobe_age_r != 4'hF};
            settle_r <= ($changed(ref_divide) || $changed(divide_total)) ? 0 : settle_r + 1;
        end
    end
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == '0)
        else $error("read data not zero outside read answer");
    a_sel_exclusive: assert property (!(tx_enable && rx_enable))
        else $error("transmit and receive both enabled");
    a_ref_range: assert property (ref_divide == '0 || ref_divide >= ssl_pkg::REF_MIN)
        else $error("reference count below minimum latched");
    a_lock_loaded: assert property (lock_indicator |-> ref_divide != '0 && divide_total != '0)
        else $error("lock shown before words loaded");
    a_lock_settle: assert property ($rose(lock_indicator) |-> settle_r >= SETTLE_CYCLES - 2)
        else $error("lock rose before settle time");
    a_tx_follows: assert property (pin_age_r == 4'hF |-> tx_enable == (!transmit_select_n && receive_select_n))
        else $error("transmit enable does not follow select pins");
    a_rx_follows: assert property (pin_age_r == 4'hF |-> rx_enable == (!receive_select_n && transmit_select_n))
        else $error("receive enable does not follow select pins");
    a_ref_hold: assert property ($changed(ref_divide) |-> strobe_age_r < 4'hA)
        else $error("reference count changed without strobe");
    a_div_hold: assert property ($changed(divide_total) |-> strobe_age_r < 4'hA)
        else $error("divide ratio changed without strobe");
    c_lock: cover property ($rose(lock_indicator));
    c_tx: cover property ($rose(tx_enable));
    c_ratio: cover property ($changed(divide_total));
endmodule
`default_nettype wire

/* File: tb/ssl_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// host side of the three wire link
// ****
module ssl_host_model (
    output logic serial_clock,
    output logic serial_data,
    output logic load_latch_strobe
);
    // link idles with clock and strobe low
    initial begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
        load_latch_strobe = 1'b0;
    end
    // shift one word msb first, then one strobe pulse
    task automatic send_word(input logic [18:0] w);
        #37;
        for (int i = 18; i >= 0; i--) begin
            serial_data = w[i];
            #400 serial_clock = 1'b1;
            #400 serial_clock = 1'b0;
        end
        serial_data = ~w[0];
        #400 load_latch_strobe = 1'b1;
        #400 load_latch_strobe = 1'b0;
    endtask
    // op bits lead the reference count, target bit last
    task automatic send_ref(input logic pre, input logic [13:0] r);
        send_word({1'b0, 1'b0, 1'b1, pre, r, 1'b1});
    endtask
    task automatic send_prog(input logic [10:0] n, input logic [6:0] a);
        send_word({n, a, 1'b0});
    endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic transmit_select_n = 1'b1;
    logic receive_select_n = 1'b1;
    logic tx_data_in = 1'b0;
    wire logic serial_clock;
    wire logic serial_data;
    wire logic load_latch_strobe;
    wire logic [31:0] reg_rdata;
    wire logic lock_indicator;
    wire logic tx_enable;
    wire logic rx_enable;
    wire logic tx_mod_data;
    wire logic [17:0] divide_total;
    wire logic [13:0] ref_divide;
    int n_mismatch = 0;
    int comparisons = 0;
    int seed = 88255;
    int cycles = 0;
    int exp_m;
    int exp_n;
    int exp_a;
    int exp_r;
    logic [31:0] rd;
    ssl_loader #(.SETTLE_CYCLES(20), .MIN_PULSE_CYCLES(4), .MAX_PULSE_CYCLES(40)) i_ssl_loader (.clk(clk),
        .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .serial_clock(serial_clock), .serial_data(serial_data),
        .load_latch_strobe(load_latch_strobe), .transmit_select_n(transmit_select_n),
        .receive_select_n(receive_select_n), .tx_data_in(tx_data_in), .lock_indicator(lock_indicator),
        .tx_enable(tx_enable), .rx_enable(rx_enable), .tx_mod_data(tx_mod_data),
        .divide_total(divide_total), .ref_divide(ref_divide));
    ssl_host_model i_ssl_host_model (.serial_clock(serial_clock), .serial_data(serial_data),
        .load_latch_strobe(load_latch_strobe));
    // clock and run limit
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // ****
    // shared tasks
    // ****
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk) reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk) reg_write <= 1'b0;
    endtask
    task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk) reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk) reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic check_model();
        check({14'h0, divide_total}, 32'(exp_m * exp_n + exp_a));
        check({18'h0, ref_divide}, 32'(exp_r));
        bus_read(ssl_pkg::ADDR_PROG, rd);
        check(rd, 32'(exp_n * 128 + exp_a));
    endtask
    task automatic wait_lock();
        for (int i = 0; i < 60 && lock_indicator !== 1'b1; i++) begin
            @(posedge clk);
        end
    endtask
    task automatic pulse(input logic v, input int n);
        @(posedge clk) tx_data_in <= v;
        repeat (n) @(posedge clk);
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus_read(ssl_pkg::ADDR_CTRL, rd);
        check(rd, 32'h1);
        bus_read(4'h2, rd);
        check(rd, 32'h0);
        bus_write(ssl_pkg::ADDR_CTRL, 32'h0);
        // example channel, program word first
        exp_m = 64;
        exp_r = 21250000 / 12500;
        exp_n = (458000000 - 21700000) / 12500 / 64;
        exp_a = (458000000 - 21700000) / 12500 - 64 * exp_n;
        i_ssl_host_model.send_prog(11'(exp_n), 7'(exp_a));
        i_ssl_host_model.send_ref(1'b0, 14'(exp_r));
        repeat (8) @(posedge clk);
        check_model();
        bus_read(ssl_pkg::ADDR_REF, rd);
        check(rd, {14'h0, 4'h2, 14'(exp_r)});
        wait_lock();
        check({31'h0, lock_indicator}, 32'h1);
        bus_read(ssl_pkg::ADDR_STATUS, rd);
        check(rd, 32'h7);
        // boundary then random legal words, both prescalers
        for (int i = 0; i < 5; i++) begin
            exp_m = (i % 2) ? 128 : 64;
            exp_r = (i == 0) ? 16383 : (i == 1) ? 3 : 3 + int'($unsigned($random(seed)) % 16381);
            exp_n = (i == 0) ? 2047 : (i == 1) ? 3 : 3 + int'($unsigned($random(seed)) % 2045);
            exp_a = (i == 0) ? 127 : (i == 1) ? 2 : int'($unsigned($random(seed)) % 128) % exp_n;
            i_ssl_host_model.send_ref(exp_m == 128, 14'(exp_r));
            i_ssl_host_model.send_prog(11'(exp_n), 7'(exp_a));
            repeat (8) @(posedge clk);
            check_model();
            check({31'h0, lock_indicator}, 32'h0);
        end
        wait_lock();
        // refused words leave latches and lock alone
        i_ssl_host_model.send_prog(11'h005, 7'h05);
        i_ssl_host_model.send_ref(1'b0, 14'h0002);
        repeat (8) @(posedge clk);
        check_model();
        check({31'h0, lock_indicator}, 32'h1);
        bus_read(ssl_pkg::ADDR_STATUS, rd);
        check(32'(rd[3]), 32'h1);
        bus_write(ssl_pkg::ADDR_STATUS, 32'h8);
        bus_read(ssl_pkg::ADDR_STATUS, rd);
        check(32'(rd[3]), 32'h0);
        bus_write(ssl_pkg::ADDR_CTRL, 32'h2);
        repeat (4) @(posedge clk);
        check({31'h0, lock_indicator}, 32'h0);
        // every select pin combination
        for (int s = 0; s < 4; s++) begin
            @(posedge clk) transmit_select_n <= s[0];
            receive_select_n <= s[1];
            repeat (8) @(posedge clk);
            check({31'h0, tx_enable}, 32'(!s[0] && s[1]));
            check({31'h0, rx_enable}, 32'(!s[1] && s[0]));
            bus_read(ssl_pkg::ADDR_STATUS, rd);
            check(32'(rd[6]), 32'(s == 0));
        end
        // transmit pulse widths, short then long
        @(posedge clk) transmit_select_n <= 1'b0;
        receive_select_n <= 1'b1;
        bus_write(ssl_pkg::ADDR_CTRL, 32'h1);
        bus_write(ssl_pkg::ADDR_STATUS, 32'h30);
        pulse(1'b1, 10);
        check({31'h0, tx_mod_data}, 32'h1);
        pulse(1'b0, 2);
        pulse(1'b1, 10);
        bus_read(ssl_pkg::ADDR_STATUS, rd);
        check(32'(rd[4]), 32'h1);
        pulse(1'b0, 50);
        bus_read(ssl_pkg::ADDR_STATUS, rd);
        check(32'(rd[5]), 32'h1);
        wait_lock();
        check({31'h0, lock_indicator}, 32'h1);
        print_verdict();
    end
endmodule
bind ssl_loader ssl_loader_properties #(.SETTLE_CYCLES(SETTLE_CYCLES), .MIN_PULSE_CYCLES(MIN_PULSE_CYCLES),
    .MAX_PULSE_CYCLES(MAX_PULSE_CYCLES)) i_ssl_loader_properties (.clk(clk), .rst(rst), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .load_latch_strobe(load_latch_strobe), .transmit_select_n(transmit_select_n),
    .receive_select_n(receive_select_n), .lock_indicator(lock_indicator), .tx_enable(tx_enable),
    .rx_enable(rx_enable), .divide_total(divide_total), .ref_divide(ref_divide));
`default_nettype wire
